// ==== verilog/gpm_params.svh ====
// gpio pin function mux: addresses, field positions, reset values
// assumes word-aligned accesses on the memory-mapped register port
`ifndef GPM_PARAMS_SVH
`define GPM_PARAMS_SVH

`define GPM_BASE        32'hffff0d00
`define GPM_OFF_CON0    8'h00
`define GPM_OFF_CON1    8'h04
`define GPM_OFF_CON2    8'h08
`define GPM_OFF_DAT0    8'h20
`define GPM_OFF_DAT1    8'h24
`define GPM_OFF_DAT2    8'h28
`define GPM_OFF_SET0    8'h30
`define GPM_OFF_SET1    8'h34
`define GPM_OFF_SET2    8'h38
`define GPM_OFF_CLR0    8'h40
`define GPM_OFF_CLR1    8'h44
`define GPM_OFF_CLR2    8'h48

`define GPM_CON0_RST    32'h11100000
`define GPM_CON1_RST    32'h10000000
`define GPM_CON2_RST    32'h01000000
`define GPM_CON0_WMASK  32'h01111111
`define GPM_CON1_WMASK  32'h00000011
`define GPM_CON2_WMASK  32'h01110000

`define GPM_C0_SS       0
`define GPM_C0_SCLK     4
`define GPM_C0_MISO     8
`define GPM_C0_MOSI     12
`define GPM_C0_CLOCK_OUTPUT_PIN     16
`define GPM_C0_HVA      20
`define GPM_C0_HVB      24
`define GPM_C1_RXD      0
`define GPM_C1_TXD      4
`define GPM_C2_STI      24

`define GPM_PIN_CLOCK_OUTPUT_PIN    4
`define GPM_PIN_RXD     5
`define GPM_PIN_TXD     6
`define GPM_PIN_P2      7
`define GPM_NPINS       9

`define GPM_DAT_DIR_HI  31
`define GPM_DAT_DIR_LO  24
`define GPM_DAT_IN_HI   23
`define GPM_DAT_IN_LO   16
`define GPM_DAT_VAL_HI  7
`define GPM_DAT_VAL_LO  0

`endif

// ==== verilog/gpm_pkg.sv ====
// gpio pin function mux: carrier types
// assumes gpm_params.svh for widths
`include "gpm_params.svh"
package gpm_pkg;
    typedef struct packed {
        logic                   wr;
        logic                   rd;
        logic [31:0]            addr;
        logic [31:0]            wdata;
    } gpm_mmr_req_t;

    typedef struct packed {
        logic [`GPM_NPINS-1:0]  o;
        logic [`GPM_NPINS-1:0]  oe;
    } gpm_pins_t;

    // lines 0..3: slave select, serial clock, miso, mosi
    typedef struct packed {
        logic [3:0]             o;
        logic [3:0]             oe;
    } gpm_spi_t;
endpackage

// ==== verilog/gpm_gpio_mux.sv ====
// gpio pin function mux: nine pins in three ports, function select,
// data/set/clear registers, level interrupt requests, power-down hold
// assumes one core clock; pins are asynchronous and synchronised here
`timescale 1ns/1ps
`include "gpm_params.svh"
module gpm_gpio_mux (
    // clock and reset
    input  wire logic                   clk,
    input  wire logic                   resetn,
    // register port
    input  wire gpm_pkg::gpm_mmr_req_t  mmr_req,
    output logic [31:0]                 rd_data,
    output logic                        rd_valid,
    // external pins
    input  wire logic [8:0]             pin_in,
    output gpm_pkg::gpm_pins_t          pin_drv,
    // peripherals
    input  wire gpm_pkg::gpm_spi_t      spi_drv,
    output logic [3:0]                  spi_in,
    input  wire logic                   clock_output_src,
    input  wire logic                   uart_txd,
    output logic                        uart_rxd,
    input  wire logic                   sti_data,
    // power and interrupts
    input  wire logic                   power_down,
    output logic [3:0]                  ext_req,
    // internal high-voltage link and diagnostics
    input  wire logic [1:0]             hv_line_in,
    output logic [1:0]                  hv_line_out,
    output logic [1:0]                  hv_line_oe,
    input  wire logic                   diag_readback_in,
    output logic                        diag_write_out,
    output logic                        sti_out
);
    import gpm_pkg::*;

    logic [8:0]  sync1_ff, sync2_ff, nxt_sync1, nxt_sync2;
    logic [31:0] con_ff [3];
    logic [31:0] nxt_con [3];
    logic [7:0]  val_ff [3];
    logic [7:0]  nxt_val [3];
    logic [7:0]  dir_ff [3];
    logic [7:0]  nxt_dir [3];
    logic [7:0]  pin_view [3];
    logic [31:0] wmask [3];
    logic [31:0] rst_val [3];
    gpm_pins_t   pin_ff, nxt_pin;
    logic [3:0]  spi_in_ff, nxt_spi_in, req_ff, nxt_req;
    logic        rxd_ff, nxt_rxd;
    logic [31:0] rdata_ff, nxt_rdata;
    logic        rvalid_ff, nxt_rvalid;
    logic [1:0]  hv_o_ff, hv_oe_ff, nxt_hv_o, nxt_hv_oe;
    logic        diag_ff, sti_ff, nxt_diag, nxt_sti;
    logic [31:0] off;
    logic [7:0]  off8;
    logic        hit;

    // two-stage pin synchroniser
    always_comb begin
        nxt_sync1 = pin_in;
        nxt_sync2 = sync1_ff;
    end
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            sync1_ff <= 9'h000;
            sync2_ff <= 9'h000;
        end else begin
            sync1_ff <= nxt_sync1;
            sync2_ff <= nxt_sync2;
        end
    end

    assign wmask   = '{`GPM_CON0_WMASK, `GPM_CON1_WMASK, `GPM_CON2_WMASK};
    assign rst_val = '{`GPM_CON0_RST, `GPM_CON1_RST, `GPM_CON2_RST};
    // input view per port; internal lines carry no pin
    assign pin_view[0] = {1'b0, hv_line_in, sync2_ff[4:0]};
    assign pin_view[1] = {6'h00, sync2_ff[6:5]};
    assign pin_view[2] = {3'h0, diag_readback_in, 2'h0, sync2_ff[8:7]};
    assign off  = mmr_req.addr - `GPM_BASE;
    assign off8 = off[7:0];
    assign hit  = (off[31:8] == 24'h000000);

    // register file: control, data, set, clear per port
    always_comb begin
        nxt_con    = con_ff;
        nxt_val    = val_ff;
        nxt_dir    = dir_ff;
        nxt_rdata  = 32'h00000000;
        nxt_rvalid = mmr_req.rd;
        for (int p = 0; p < 3; p++) begin
            if (mmr_req.wr && hit && off8 == `GPM_OFF_CON0 + 8'(4 * p)) begin
                // reserved bits keep their reset values
                nxt_con[p] = (mmr_req.wdata & wmask[p]) | (rst_val[p] & ~wmask[p]);
            end
            if (mmr_req.wr && hit && off8 == `GPM_OFF_DAT0 + 8'(4 * p)) begin
                nxt_dir[p] = mmr_req.wdata[`GPM_DAT_DIR_HI:`GPM_DAT_DIR_LO];
                nxt_val[p] = mmr_req.wdata[`GPM_DAT_VAL_HI:`GPM_DAT_VAL_LO];
            end
            if (mmr_req.wr && hit && off8 == `GPM_OFF_SET0 + 8'(4 * p)) begin
                nxt_val[p] = val_ff[p] | mmr_req.wdata[`GPM_DAT_VAL_HI:`GPM_DAT_VAL_LO];
            end
            if (mmr_req.wr && hit && off8 == `GPM_OFF_CLR0 + 8'(4 * p)) begin
                nxt_val[p] = val_ff[p] & ~mmr_req.wdata[`GPM_DAT_VAL_HI:`GPM_DAT_VAL_LO];
            end
            if (mmr_req.rd && hit && off8 == `GPM_OFF_CON0 + 8'(4 * p)) begin
                nxt_rdata = con_ff[p];
            end
            if (mmr_req.rd && hit && off8 == `GPM_OFF_DAT0 + 8'(4 * p)) begin
                nxt_rdata = {dir_ff[p], pin_view[p], 8'h00, val_ff[p]};
            end
        end
    end
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            con_ff[0] <= `GPM_CON0_RST;
            con_ff[1] <= `GPM_CON1_RST;
            con_ff[2] <= `GPM_CON2_RST;
            val_ff    <= '{3{8'h00}};
            dir_ff    <= '{3{8'h00}};
            rdata_ff  <= 32'h00000000;
            rvalid_ff <= 1'b0;
        end else begin
            con_ff    <= nxt_con;
            val_ff    <= nxt_val;
            dir_ff    <= nxt_dir;
            rdata_ff  <= nxt_rdata;
            rvalid_ff <= nxt_rvalid;
        end
    end

    // pin routing; power-down freezes the driven levels
    always_comb begin
        nxt_pin = pin_ff;
        if (!power_down) begin
            for (int i = 0; i < 5; i++) begin
                nxt_pin.o[i]  = val_ff[0][i];
                nxt_pin.oe[i] = dir_ff[0][i];
            end
            for (int i = 0; i < 4; i++) begin
                if (con_ff[0][4 * i]) begin
                    nxt_pin.o[i]  = spi_drv.o[i];
                    nxt_pin.oe[i] = spi_drv.oe[i];
                end
            end
            if (con_ff[0][`GPM_C0_CLOCK_OUTPUT_PIN]) begin
                nxt_pin.o[`GPM_PIN_CLOCK_OUTPUT_PIN]  = clock_output_src;
                nxt_pin.oe[`GPM_PIN_CLOCK_OUTPUT_PIN] = 1'b1;
            end
            nxt_pin.o[6:5]  = val_ff[1][1:0];
            nxt_pin.oe[6:5] = dir_ff[1][1:0];
            if (con_ff[1][`GPM_C1_RXD]) begin
                nxt_pin.oe[`GPM_PIN_RXD] = 1'b0;
            end
            if (con_ff[1][`GPM_C1_TXD]) begin
                nxt_pin.o[`GPM_PIN_TXD]  = uart_txd;
                nxt_pin.oe[`GPM_PIN_TXD] = 1'b1;
            end
            nxt_pin.o[8:7]  = val_ff[2][1:0];
            nxt_pin.oe[8:7] = dir_ff[2][1:0];
        end
        nxt_spi_in = sync2_ff[3:0];
        nxt_rxd    = con_ff[1][`GPM_C1_RXD] & sync2_ff[`GPM_PIN_RXD];
        // level requests, not latched
        nxt_req    = {sync2_ff[8:7], sync2_ff[5], sync2_ff[0]};
        nxt_hv_o   = val_ff[0][6:5];
        nxt_hv_oe  = dir_ff[0][6:5] & {con_ff[0][`GPM_C0_HVB], con_ff[0][`GPM_C0_HVA]};
        nxt_diag   = val_ff[2][5];
        nxt_sti    = con_ff[2][`GPM_C2_STI] ? sti_data : val_ff[2][6];
    end
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            pin_ff    <= '0;
            spi_in_ff <= 4'h0;
            rxd_ff    <= 1'b0;
            req_ff    <= 4'h0;
            hv_o_ff   <= 2'h0;
            hv_oe_ff  <= 2'h0;
            diag_ff   <= 1'b0;
            sti_ff    <= 1'b0;
        end else begin
            pin_ff    <= nxt_pin;
            spi_in_ff <= nxt_spi_in;
            rxd_ff    <= nxt_rxd;
            req_ff    <= nxt_req;
            hv_o_ff   <= nxt_hv_o;
            hv_oe_ff  <= nxt_hv_oe;
            diag_ff   <= nxt_diag;
            sti_ff    <= nxt_sti;
        end
    end

    assign rd_data        = rdata_ff;
    assign rd_valid       = rvalid_ff;
    assign pin_drv        = pin_ff;
    assign spi_in         = spi_in_ff;
    assign uart_rxd       = rxd_ff;
    assign ext_req        = req_ff;
    assign hv_line_out    = hv_o_ff;
    assign hv_line_oe     = hv_oe_ff;
    assign diag_write_out = diag_ff;
    assign sti_out        = sti_ff;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);

    sequence active_s;
        !power_down;
    endsequence
    sequence req_held_s;
        pin_in[0] [*4];
    endsequence

    clock_output_pin_route_a: assert property (active_s and con_ff[0][16] |=>
        pin_drv.oe[4] && pin_drv.o[4] == $past(clock_output_src))
        else $error("clock output not on pin4");
    mosi_route_a: assert property (active_s and con_ff[0][12] |=>
        pin_drv.o[3] == $past(spi_drv.o[3]) && pin_drv.oe[3] == $past(spi_drv.oe[3]))
        else $error("mosi not routed");
    miso_route_a: assert property (active_s and con_ff[0][8] |=>
        pin_drv.o[2] == $past(spi_drv.o[2]) && pin_drv.oe[2] == $past(spi_drv.oe[2]))
        else $error("miso not routed");
    sclk_route_a: assert property (active_s and con_ff[0][4] |=>
        pin_drv.o[1] == $past(spi_drv.o[1]) && pin_drv.oe[1] == $past(spi_drv.oe[1]))
        else $error("sclk not routed");
    ss_gpio_a: assert property (active_s and !con_ff[0][0] |=>
        pin_drv.o[0] == $past(val_ff[0][0]) && pin_drv.oe[0] == $past(dir_ff[0][0]))
        else $error("pin0 gpio path wrong");
    pd_hold_a: assert property (power_down |=> $stable(pin_drv))
        else $error("pin moved in power-down");
    ext_req_a: assert property (req_held_s |-> ext_req[0])
        else $error("held request not seen");
    ctrl_reset_a: assert property ($rose(resetn) |-> con_ff[0] == `GPM_CON0_RST)
        else $error("port0 control reset value wrong");
    reserved_keep_a: assert property (
        (con_ff[0] & ~`GPM_CON0_WMASK) == (`GPM_CON0_RST & ~`GPM_CON0_WMASK))
        else $error("reserved control bits changed");
    uart_tx_a: assert property (active_s and con_ff[1][4] |=>
        pin_drv.oe[6] && pin_drv.o[6] == $past(uart_txd))
        else $error("uart tx not on pin6");
    hv_gate_a: assert property (!con_ff[0][20] |=> !hv_line_oe[0])
        else $error("hv line a driven while disabled");
endmodule

// ==== bench/gpm_pin_board.sv ====
// board model: pull-ups and external drivers on the nine pins
// assumes the mux pin bundle; board drives a pin only where src_en is set
`timescale 1ns/1ps
module gpm_pin_board (
    // mux side
    input  wire gpm_pkg::gpm_pins_t pin_drv,
    output logic [8:0]              pin_in,
    // board sources
    input  wire logic [8:0]         src_val,
    input  wire logic [8:0]         src_en
);
    import gpm_pkg::*;
    always_comb begin
        for (int i = 0; i < 9; i++) begin
            // released pins with src_en clear sit at the pull-up level
            pin_in[i] = pin_drv.oe[i] ? pin_drv.o[i] : (src_en[i] ? src_val[i] : 1'b1);
        end
    end
endmodule

// ==== bench/gpio_pin_function_mux_tb.sv ====
// testbench for the pin function mux: registers, routing, requests, hold
// assumes gpm_gpio_mux and the board model; inputs change on falling edges
`timescale 1ns/1ps
`include "gpm_params.svh"
module gpio_pin_function_mux_tb;
    import gpm_pkg::*;
    logic         clk, resetn, power_down, clock_output_src, uart_txd;
    logic         rd_valid, uart_rxd, diag_write_out, sti_out, sti_data, diag_readback_in;
    logic [31:0]  rd_data;
    logic [8:0]   pin_in, src_val, src_en;
    logic [3:0]   spi_in, ext_req;
    logic [1:0]   hv_line_out, hv_line_oe, hv_line_in;
    gpm_mmr_req_t req;
    gpm_spi_t     spi_drv;
    gpm_pins_t    pin_drv;
    int           err_total, n_tests;
    int           pins[4] = '{0, 5, 7, 8};

    gpm_gpio_mux dut_u (.clk(clk), .resetn(resetn), .mmr_req(req), .rd_data(rd_data),
        .rd_valid(rd_valid), .pin_in(pin_in), .pin_drv(pin_drv), .spi_drv(spi_drv),
        .spi_in(spi_in), .clock_output_src(clock_output_src), .uart_txd(uart_txd),
        .uart_rxd(uart_rxd), .sti_data(sti_data), .power_down(power_down), .ext_req(ext_req),
        .hv_line_in(hv_line_in), .hv_line_out(hv_line_out), .hv_line_oe(hv_line_oe),
        .diag_readback_in(diag_readback_in), .diag_write_out(diag_write_out),
        .sti_out(sti_out));
    gpm_pin_board board_u (.pin_drv(pin_drv), .pin_in(pin_in), .src_val(src_val),
        .src_en(src_en));

    task automatic stop_test;
        $display("errors %0d checks %0d", err_total, n_tests);
        if (err_total == 0 && n_tests > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    task automatic chk(input bit ok, input string msg);
        n_tests++;
        if (!ok) begin
            err_total++;
            $display("Error %0t: %s", $time, msg);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(negedge clk);
    endtask
    task automatic wr(input logic [7:0] off, input logic [31:0] d);
        @(negedge clk);
        req = '{wr: 1'b1, rd: 1'b0, addr: `GPM_BASE + {24'h0, off}, wdata: d};
        @(negedge clk);
        req.wr = 1'b0;
    endtask
    task automatic rd(input logic [7:0] off, input logic [31:0] exp);
        @(negedge clk);
        req = '{wr: 1'b0, rd: 1'b1, addr: `GPM_BASE + {24'h0, off}, wdata: 32'h0};
        @(negedge clk);
        req.rd = 1'b0;
        chk(rd_valid === 1'b1 && rd_data === exp, "read value wrong");
    endtask

    task automatic t_reset;
        chk(pin_drv.oe === 9'h000, "pins driven after reset");
        rd(`GPM_OFF_CON0, 32'h11100000);
        rd(`GPM_OFF_CON1, 32'h10000000);
        rd(`GPM_OFF_CON2, 32'h01000000);
        rd(8'h10, 32'h0);
        rd(`GPM_OFF_SET0, 32'h0);
    endtask
    task automatic t_reserved;
        wr(`GPM_OFF_CON0, 32'hffffffff);
        rd(`GPM_OFF_CON0, 32'h11111111);
        wr(`GPM_OFF_CON0, 32'h00000000);
        rd(`GPM_OFF_CON0, 32'h10000000);
    endtask
    task automatic t_irq;
        src_en = 9'h1ff;
        src_val = 9'h000;
        cyc(4);
        chk(ext_req === 4'h0, "request without source");
        for (int i = 0; i < 4; i++) begin
            src_val = 9'h001 << pins[i];
            cyc(4);
            chk(ext_req === (4'h1 << i), "request on wrong line");
        end
        src_en = 9'h000;
    endtask
    task automatic t_spi;
        spi_drv = '{o: 4'h5, oe: 4'hf};
        wr(`GPM_OFF_CON0, 32'h10001111);
        cyc(1);
        chk(pin_drv.o[3:0] === 4'h5 && pin_drv.oe[3:0] === 4'hf, "spi route");
        cyc(3);
        chk(spi_in === 4'h5, "spi input path");
        wr(`GPM_OFF_CON0, 32'h10000000);
        cyc(1);
        chk(pin_drv.oe[3:0] === 4'h0, "spi pins not released");
    endtask
    task automatic t_clock_output_pin;
        clock_output_src = 1'b1;
        wr(`GPM_OFF_CON0, 32'h10010000);
        cyc(1);
        chk(pin_drv.oe[4] === 1'b1 && pin_drv.o[4] === 1'b1, "clock pin high");
        clock_output_src = 1'b0;
        cyc(1);
        chk(pin_drv.o[4] === 1'b0, "clock pin low");
        wr(`GPM_OFF_CON0, 32'h10000000);
        cyc(1);
        chk(pin_drv.oe[4] === 1'b0, "clock pin not released");
    endtask
    task automatic t_uart;
        uart_txd = 1'b1;
        src_en = 9'h020;
        src_val = 9'h000;
        wr(`GPM_OFF_CON1, 32'h00000011);
        cyc(4);
        chk(pin_drv.o[6] === 1'b1 && pin_drv.oe[5] === 1'b0 && uart_rxd === 1'b0, "uart");
        src_val = 9'h020;
        uart_txd = 1'b0;
        cyc(4);
        chk(pin_drv.o[6] === 1'b0 && uart_rxd === 1'b1, "uart follow");
        wr(`GPM_OFF_CON1, 32'h10000000);
        src_en = 9'h000;
    endtask
    task automatic t_hv;
        wr(`GPM_OFF_DAT0, 32'h60000000);
        wr(`GPM_OFF_CON0, 32'h10100000);
        cyc(1);
        chk(hv_line_oe === 2'b01 && pin_drv.oe === 9'h000, "line a enable");
        wr(`GPM_OFF_CON0, 32'h11000000);
        cyc(1);
        chk(hv_line_oe === 2'b10, "line b enable");
        wr(`GPM_OFF_CON0, 32'h10000000);
        cyc(1);
        chk(hv_line_oe === 2'b00, "lines off");
        wr(`GPM_OFF_DAT0, 32'h00000000);
    endtask
    task automatic t_pd;
        wr(`GPM_OFF_DAT0, 32'h01000001);
        cyc(1);
        chk(pin_drv.o[0] === 1'b1 && pin_drv.oe[0] === 1'b1, "gpio drive");
        @(negedge clk);
        power_down = 1'b1;
        wr(`GPM_OFF_CLR0, 32'h00000001);
        cyc(2);
        chk(pin_drv.o[0] === 1'b1 && pin_drv.oe[0] === 1'b1, "level not held");
        power_down = 1'b0;
        cyc(2);
        chk(pin_drv.o[0] === 1'b0, "clear not applied");
        wr(`GPM_OFF_DAT0, 32'h00000000);
    endtask
    // internal-only lines: sti, diagnostic write/readback, high-voltage link
    task automatic t_diag;
        sti_data = 1'b1;
        cyc(1);
        chk(sti_out === 1'b1, "sti data not routed");
        sti_data = 1'b0;
        wr(`GPM_OFF_CON2, 32'h00000000);
        wr(`GPM_OFF_SET2, 32'h00000060);
        cyc(1);
        chk(diag_write_out === 1'b1 && sti_out === 1'b1, "port2 internal lines");
        diag_readback_in = 1'b1;
        hv_line_in = 2'b11;
        rd(`GPM_OFF_DAT2, 32'h00130060);
        rd(`GPM_OFF_DAT0, 32'h007f0000);
        wr(`GPM_OFF_DAT0, 32'h00000060);
        cyc(1);
        chk(hv_line_out === 2'b11 && pin_drv.oe[4:0] === 5'h00, "hv line values");
        wr(`GPM_OFF_DAT0, 32'h00000000);
        wr(`GPM_OFF_CLR2, 32'h00000060);
        cyc(1);
        chk(diag_write_out === 1'b0 && hv_line_out === 2'b00, "port2 clear");
    endtask

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    initial begin
        #50us;
        err_total++;
        stop_test();
    end
    initial begin
        resetn = 1'b0;
        power_down = 1'b0;
        clock_output_src = 1'b0;
        uart_txd = 1'b0;
        sti_data = 1'b0;
        hv_line_in = 2'b00;
        diag_readback_in = 1'b0;
        src_val = 9'h000;
        src_en = 9'h000;
        req = '0;
        spi_drv = '0;
        err_total = 0;
        n_tests = 0;
        cyc(16);
        resetn = 1'b1;
        t_reset();
        t_irq();
        t_reserved();
        t_spi();
        t_clock_output_pin();
        t_uart();
        t_hv();
        t_pd();
        t_diag();
        stop_test();
    end
endmodule
